// >>> common/usbeps_pkg.sv
// package for the control-endpoint setup handshake block
// assumes a 25 MHz system clock and a token decoder upstream
package usbeps_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int  CLK_PERIOD_NS    = 40;
  // hazard window of one bit time at full speed
  localparam int  CRC_BIT_NS       = 83;
  localparam int  CRC_BIT_CYCLES   = (CRC_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // handshake and packet codes
  // ****************************************
  localparam logic [1:0] RESP_NONE = 2'h0;
  localparam logic [1:0] RESP_NAK  = 2'h1;
  localparam logic [1:0] RESP_DATA = 2'h2;

  localparam logic [3:0] TX_LEN_RESET = 4'h0;
  localparam logic [3:0] TX_CNT_ONE   = 4'h1;

  typedef enum logic [1:0] {
    USBEPS_TX_IDLE,
    USBEPS_TX_NAK,
    USBEPS_TX_DATA
  } usbeps_tx_state_type;

endpackage : usbeps_pkg

// >>> design/usbeps_sync.sv
// two-flop synchroniser for a group of level inputs
// assumes inputs are quasi-static relative to sys_clk
`timescale 1ns/1ps
module usbeps_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  // ****************************************
  // per-bit two-stage chain
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_comb begin
        meta_next[gi] = async_in[gi];
        sync_next[gi] = meta_reg[gi];
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;

endmodule : usbeps_sync

// >>> design/usbeps_ctrl.sv
// control endpoint zero setup handshake: flag, interrupt, nak and data answer
// assumes token strobes come from same-clock logic; enables are software pins
// and pass the synchroniser; a crc-bit strobe marks the second crc bit window
`timescale 1ns/1ps
module usbeps_ctrl
  import usbeps_pkg::*;
#(
  parameter int         HOLD_CYCLES = CRC_BIT_CYCLES,
  parameter logic [3:0] DATA_LEN    = 4'h8
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // software controls (pins, asynchronous)
  input  wire logic       module_enable,
  input  wire logic       in_ep0_active_enable,
  input  wire logic       out_ep0_active_enable,
  input  wire logic       setup_flag_clear,
  // token decoder, same clock, one-cycle pulses
  input  wire logic       setup_token,
  input  wire logic       in_token,
  input  wire logic       crc_bit2,
  // status to software
  output logic            setup_received_flag,
  output logic            usb_interrupt,
  // handshake engine
  output logic [1:0]      tx_response,
  output logic            tx_active
);

  logic [3:0] sync_out;
  logic       en_s;
  logic       in_en_s;
  logic       out_en_s;
  logic       clr_s;

  usbeps_sync #(.WIDTH(4)) u_sync (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .async_in ({setup_flag_clear, out_ep0_active_enable, in_ep0_active_enable, module_enable}),
    .sync_out (sync_out)
  );

  always_comb begin
    en_s     = sync_out[0];
    in_en_s  = sync_out[1];
    out_en_s = sync_out[2];
    clr_s    = sync_out[3];
  end

  // ****************************************
  // setup flag state
  // ****************************************
  logic                flag_reg;
  logic                flag_next;
  logic                irq_reg;
  logic                irq_next;
  logic                clr_d_reg;
  logic                clr_d_next;
  logic                pend_clr_reg;
  logic                pend_clr_next;
  logic                clr_event;
  logic                clr_gated;

  // edge of the clear level after synchronisation
  always_comb begin
    clr_event = clr_s & ~clr_d_reg;
    clr_gated = clr_event & (in_en_s | out_en_s);
  end

  // hazard window counter
  logic [7:0] win_reg;
  logic [7:0] win_next;
  logic       in_window;

  always_comb begin
    in_window = (win_reg != 8'h00);
    win_next  = win_reg;
    if (crc_bit2) begin
      win_next = 8'(HOLD_CYCLES);
    end else if (in_window) begin
      win_next = win_reg - 8'h01;
    end
    if (!en_s) begin
      win_next = 8'h00;
    end
  end

  always_comb begin
    flag_next     = flag_reg;
    pend_clr_next = pend_clr_reg;
    clr_d_next    = clr_s;
    if (clr_gated && (in_window || crc_bit2)) begin
      pend_clr_next = 1'b1;
    end else if (clr_gated || (pend_clr_reg && !in_window && !crc_bit2)) begin
      flag_next     = 1'b0;
      pend_clr_next = 1'b0;
    end
    if (setup_token) begin
      flag_next     = 1'b1;
      pend_clr_next = 1'b0;
    end
    irq_next = flag_next;
    if (!en_s) begin
      flag_next     = 1'b0;
      pend_clr_next = 1'b0;
      irq_next      = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      flag_reg     <= 1'b0;
      irq_reg      <= 1'b0;
      clr_d_reg    <= 1'b0;
      pend_clr_reg <= 1'b0;
      win_reg      <= 8'h00;
    end else begin
      flag_reg     <= flag_next;
      irq_reg      <= irq_next;
      clr_d_reg    <= clr_d_next;
      pend_clr_reg <= pend_clr_next;
      win_reg      <= win_next;
    end
  end

  // ****************************************
  // handshake transmitter
  // ****************************************
  usbeps_tx_state_type tx_state_reg;
  usbeps_tx_state_type tx_state_next;
  logic [3:0]          tx_cnt_reg;
  logic [3:0]          tx_cnt_next;
  logic [1:0]          resp_reg;
  logic [1:0]          resp_next;
  logic                act_reg;
  logic                act_next;

  // bounded length keeps the sender from running on forever
  always_comb begin
    tx_state_next = tx_state_reg;
    tx_cnt_next   = tx_cnt_reg;
    resp_next     = RESP_NONE;
    act_next      = 1'b0;
    case (tx_state_reg)
      USBEPS_TX_IDLE: begin
        if (in_token && en_s && (in_en_s || out_en_s)) begin
          if (flag_reg) begin
            tx_state_next = USBEPS_TX_NAK;
            resp_next     = RESP_NAK;
            act_next      = 1'b1;
          end else begin
            tx_state_next = USBEPS_TX_DATA;
            tx_cnt_next   = DATA_LEN;
            resp_next     = RESP_DATA;
            act_next      = 1'b1;
          end
        end
      end
      USBEPS_TX_NAK: begin
        tx_state_next = USBEPS_TX_IDLE;
      end
      USBEPS_TX_DATA: begin
        resp_next = RESP_DATA;
        act_next  = 1'b1;
        if (tx_cnt_reg <= TX_CNT_ONE) begin
          tx_state_next = USBEPS_TX_IDLE;
          tx_cnt_next   = TX_LEN_RESET;
          resp_next     = RESP_NONE;
          act_next      = 1'b0;
        end else begin
          tx_cnt_next = tx_cnt_reg - TX_CNT_ONE;
        end
      end
      default: begin
        tx_state_next = USBEPS_TX_IDLE;
        tx_cnt_next   = TX_LEN_RESET;
      end
    endcase
    if (!en_s) begin
      tx_state_next = USBEPS_TX_IDLE;
      tx_cnt_next   = TX_LEN_RESET;
      resp_next     = RESP_NONE;
      act_next      = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_state_reg <= USBEPS_TX_IDLE;
      tx_cnt_reg   <= TX_LEN_RESET;
      resp_reg     <= RESP_NONE;
      act_reg      <= 1'b0;
    end else begin
      tx_state_reg <= tx_state_next;
      tx_cnt_reg   <= tx_cnt_next;
      resp_reg     <= resp_next;
      act_reg      <= act_next;
    end
  end

  assign setup_received_flag = flag_reg;
  assign usb_interrupt       = irq_reg;
  assign tx_response         = resp_reg;
  assign tx_active           = act_reg;

endmodule : usbeps_ctrl

// >>> tb/usbeps_host_model.sv
// host side token source for the setup handshake block
// assumes callers wait for each answer before sending on
`timescale 1ns/1ps
module usbeps_host_model (
  // clock
  input  wire logic sys_clk,
  // tokens, one-cycle pulses
  output logic      setup_token,
  output logic      in_token,
  output logic      crc_bit2
);
  initial {setup_token, in_token, crc_bit2} = 3'h0;

  // one pulse, launched and dropped on rising edges
  task automatic tok(input logic [2:0] w);
    @(posedge sys_clk);
    {setup_token, in_token, crc_bit2} <= w;
    @(posedge sys_clk);
    {setup_token, in_token, crc_bit2} <= 3'h0;
  endtask : tok
endmodule : usbeps_host_model

// >>> tb/usbeps_ctrl_properties.sv
// assertions on the setup handshake ports
// assumes enables stay quiet around tokens
`timescale 1ns/1ps
module usbeps_ctrl_chk
  import usbeps_pkg::*;
#(
  parameter int         HOLD_CYCLES = 3,
  parameter logic [3:0] DATA_LEN    = 4'h8
) (
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire logic       module_enable,
  input wire logic       in_ep0_active_enable,
  input wire logic       out_ep0_active_enable,
  input wire logic       setup_flag_clear,
  input wire logic       setup_token,
  input wire logic       in_token,
  input wire logic       crc_bit2,
  input wire logic       setup_received_flag,
  input wire logic       usb_interrupt,
  input wire logic [1:0] tx_response,
  input wire logic       tx_active
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic       en_ok;
  logic [4:0] act_run_reg;
  // tokens only count when idle and some endpoint is on
  assign en_ok = module_enable && (in_ep0_active_enable || out_ep0_active_enable) && !tx_active;
  // run length of the sender, saturating so it cannot wrap back to legal
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      act_run_reg <= 5'h00;
    end else if (!tx_active) begin
      act_run_reg <= 5'h00;
    end else if (act_run_reg != 5'h1f) begin
      act_run_reg <= act_run_reg + 5'h01;
    end
  end
  // default burst: the load cycle plus seven count-down cycles
  sequence data_burst;
    (tx_active && tx_response == RESP_DATA) [*8] ##1 !tx_active;
  endsequence
  chk_setup_sets: assert property (setup_token && module_enable |=> setup_received_flag)
    else $error("setup did not set flag");
  chk_irq_mirror: assert property (usb_interrupt == setup_received_flag)
    else $error("interrupt differs from flag");
  chk_nak_pending: assert property (in_token && en_ok && setup_received_flag |=>
    tx_response == RESP_NAK ##1 !tx_active) else $error("no nak while flag set");
  chk_data_after: assert property (disable iff (!nrst || !module_enable)
    in_token && en_ok && !setup_received_flag |=> data_burst) else $error("no data burst");
  chk_tx_bounded: assert property (act_run_reg <= 5'(DATA_LEN))
    else $error("transmitter runs on");
  chk_clear_window: assert property (setup_received_flag && crc_bit2 |=> setup_received_flag [*3])
    else $error("flag cleared in crc window");
  chk_disable_idle: assert property (!module_enable [*4] |-> !setup_received_flag && !tx_active)
    else $error("disable left state");
  chk_clear_gated: assert property ((setup_received_flag && module_enable && !in_ep0_active_enable
    && !out_ep0_active_enable) [*4] |=> setup_received_flag) else $error("gated clear taken");
endmodule : usbeps_ctrl_chk

bind usbeps_ctrl usbeps_ctrl_chk #(.HOLD_CYCLES(HOLD_CYCLES), .DATA_LEN(DATA_LEN)) u_chk (
  .sys_clk, .nrst, .module_enable, .in_ep0_active_enable, .out_ep0_active_enable, .setup_flag_clear,
  .setup_token, .in_token, .crc_bit2, .setup_received_flag, .usb_interrupt, .tx_response, .tx_active);

// >>> tb/test_usb_ep0_setup_handshake.sv
// self-checking bench for the setup handshake block
// assumes the host model answers task calls at rising edges
`timescale 1ns/1ps
module test_usb_ep0_setup_handshake
  import usbeps_pkg::*;
;
  logic       sys_clk = 1'b0;
  logic       nrst = 1'b0;
  logic       module_enable = 1'b1;
  logic       in_ep0_active_enable = 1'b1;
  logic       out_ep0_active_enable = 1'b1;
  logic       setup_flag_clear = 1'b0;
  logic       setup_token, in_token, crc_bit2, setup_received_flag, usb_interrupt, tx_active;
  logic       act_d = 1'b0;
  logic [1:0] tx_response, e;
  logic [1:0] exp_q[$];
  int         bad_count = 0, n_checks = 0, cyc = 0;
  integer     seed = 57;

  always #20 sys_clk = ~sys_clk;
  usbeps_host_model u_host (.sys_clk, .setup_token, .in_token, .crc_bit2);
  usbeps_ctrl u_dut (.sys_clk, .nrst, .module_enable, .in_ep0_active_enable, .out_ep0_active_enable,
    .setup_flag_clear, .setup_token, .in_token, .crc_bit2, .setup_received_flag, .usb_interrupt,
    .tx_response, .tx_active);

  task automatic chk(input logic [1:0] got, input logic [1:0] want);
    n_checks++;
    if (got !== want) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : idle
  // note the answer first, then send the token
  task automatic tok(input logic [2:0] w, input logic [1:0] r);
    if (r != RESP_NONE) exp_q.push_back(r);
    u_host.tok(w);
  endtask : tok
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  // an answer with no note behind it counts as a mismatch
  always @(posedge sys_clk) begin
    act_d <= tx_active;
    if (tx_active === 1'b1 && act_d === 1'b0) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 2'h3;
      chk(tx_response, e);
    end
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      finish_test;
    end
  end

  initial begin
    idle(12);
    nrst <= 1'b1;
    idle(6);
    tok(3'h4, RESP_NONE);
    idle(2);
    chk({setup_received_flag, usb_interrupt}, 2'h3);
    tok(3'h2, RESP_NAK);
    idle(4);
    {in_ep0_active_enable, out_ep0_active_enable} <= 2'h0;
    idle(4);
    setup_flag_clear <= 1'b1;
    idle(6);
    tok(3'h2, RESP_NONE);
    chk({1'b0, setup_received_flag}, 2'h1);
    {in_ep0_active_enable, out_ep0_active_enable} <= 2'h3;
    setup_flag_clear <= 1'b0;
    idle(6);
    // clear rises one cycle before the crc bit
    setup_flag_clear <= 1'b1;
    tok(3'h1, RESP_NONE);
    // late enough that an undeferred clear would already show
    idle(3);
    chk({1'b0, setup_received_flag}, 2'h1);
    idle(6);
    chk({1'b0, setup_received_flag}, 2'h0);
    tok(3'h2, RESP_DATA);
    idle(10);
    // disable cuts a burst short
    tok(3'h2, RESP_DATA);
    tok(3'h4, RESP_NONE);
    module_enable <= 1'b0;
    idle(4);
    chk({setup_received_flag, tx_active}, 2'h0);
    module_enable <= 1'b1;
    idle(6);
    for (int i = 0; i < 3; i++) begin
      tok(3'h2, RESP_DATA);
      idle($unsigned($random(seed)) % 3);
      tok(3'h2, RESP_NONE);
      // either endpoint enable alone keeps tokens live
      {in_ep0_active_enable, out_ep0_active_enable} <= 2'($unsigned($random(seed)) % 3 + 1);
      idle(10);
    end
    chk(2'(exp_q.size()), 2'h0);
    finish_test;
  end
endmodule : test_usb_ep0_setup_handshake
